// ### design/mac_entry_pkg.sv
/*
 Shared constants and types for the address-table entry register bank.
 Assumes one 40 MHz system clock and 32-bit register words.
*/
package mac_entry_pkg;

   // ==========================================
   // Register map (byte offsets)
   localparam int WORDS = 4;
   localparam logic [15:0] WORD_OFF [WORDS] =
      '{16'h0420, 16'h0424, 16'h0428, 16'h042C};
   localparam logic [15:0] CTRL_OFF = 16'h041C;

   // ==========================================
   // Entry word fields
   localparam int STATIC_BIT = 31;
   localparam int SRC_DROP_BIT = 30;
   localparam int DST_DROP_BIT = 29;
   localparam int PRIO_LSB = 26;
   localparam int PRIO_W = 3;
   localparam int GROUP_LSB = 0;
   localparam int GROUP_W = 3;
   localparam int BYPASS_BIT = 31;
   localparam int FWD_W = 7;
   localparam int FGID_LSB = 16;
   localparam int FGID_W = 7;
   localparam int MACHI_W = 16;
   localparam logic [31:0] WORD_MASK [WORDS] =
      '{32'hFC00_0007, 32'h8000_007F, 32'h007F_FFFF, 32'hFFFF_FFFF};
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [PRIO_W-1:0] AGE_DEFAULT = 3'h7;

   // ==========================================
   // Control register fields
   localparam int IDX_LSB = 0;
   localparam int IDX_W = 6;
   localparam int SEL_BIT = 8;
   localparam int ACT_BIT = 9;
   localparam int GO_BIT = 12;
   localparam int STATIC_ENTRIES = 16;
   localparam int STATIC_IDX_W = 4;

   // ==========================================
   // Timing
   localparam int CLK_NS = 25;
   localparam int OP_TIME_NS = 50;
   localparam int OP_CYCLES = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYCLES - 1);

   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] fwd;
      logic [31:0] fidmac;
      logic [31:0] maclo;
   } entry_type;

   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} op_state_type;

   // Static, or dynamic with a live age
   function automatic logic entry_live(input logic [31:0] f);
      return f[STATIC_BIT] || (f[PRIO_LSB +: PRIO_W] != '0);
   endfunction

endpackage

// ### design/table_if.sv
/*
 Carrier between the register bank and the static table.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface table_if;
   import mac_entry_pkg::*;
   logic wr_en;
   logic [STATIC_IDX_W-1:0] idx;
   entry_type wdata;
   entry_type rdata;
   logic [47:0] da;
   logic [47:0] sa;
   logic [FGID_W-1:0] fgid;
   logic [GROUP_W-1:0] group;
   logic da_hit;
   entry_type da_entry;
   logic sa_drop;
   modport user (output wr_en, idx, wdata, da, sa, fgid, group,
      input rdata, da_hit, da_entry, sa_drop);
   modport store (input wr_en, idx, wdata, da, sa, fgid, group,
      output rdata, da_hit, da_entry, sa_drop);
endinterface
`default_nettype wire

// ### design/static_table.sv
/*
 Static address table: indexed storage plus parallel address search.
 Assumes the index stays stable while a write is pulsed.
*/
`timescale 1ns/1ps
`default_nettype none
module static_table
   import mac_entry_pkg::*;
#(
   parameter int ENTRIES = STATIC_ENTRIES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   table_if.store port
);
   entry_type mem [ENTRIES];
   logic [ENTRIES-1:0] da_m;
   logic [ENTRIES-1:0] sa_m;

   // Only the host writes here; aging never touches it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < ENTRIES; i++)
            mem[i] <= '0;
      end
      else if (port.wr_en)
         mem[port.idx] <= port.wdata;
   end

   assign port.rdata = mem[port.idx];

   for (genvar i = 0; i < ENTRIES; i++)
   begin : g_cmp
      logic [47:0] mac;
      assign mac = {mem[i].fidmac[MACHI_W-1:0], mem[i].maclo};
      assign da_m[i] = mem[i].flags[STATIC_BIT] && mac == port.da
         && mem[i].flags[GROUP_LSB +: GROUP_W] == port.group
         && mem[i].fidmac[FGID_LSB +: FGID_W] == port.fgid;
      assign sa_m[i] = mem[i].flags[STATIC_BIT] && mac == port.sa
         && mem[i].flags[SRC_DROP_BIT];
   end

   // Lowest index wins when several entries match
   always_comb
   begin
      port.da_entry = '0;
      for (int i = ENTRIES - 1; i >= 0; i--)
         if (da_m[i])
            port.da_entry = mem[i];
   end

   assign port.da_hit = |da_m;
   assign port.sa_drop = |sa_m;
endmodule
`default_nettype wire

// ### design/entry_ager.sv
/*
 Aging_counter update for one dynamic entry flags word.
 Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module entry_ager
   import mac_entry_pkg::*;
(
   input wire logic [31:0] flags_i,
   input wire logic learn_i,
   output logic [31:0] flags_o,
   output logic valid_o
);
   logic [PRIO_W-1:0] age;
   assign age = flags_i[PRIO_LSB +: PRIO_W];

   // Static entries keep their priority untouched
   always_comb
   begin
      flags_o = flags_i;
      if (!flags_i[STATIC_BIT])
      begin
         if (learn_i)
            flags_o[PRIO_LSB +: PRIO_W] = AGE_DEFAULT;
         else if (age != '0)
            flags_o[PRIO_LSB +: PRIO_W] = age - 1'b1;
      end
   end

   assign valid_o = entry_live(flags_o);
endmodule
`default_nettype wire

// ### design/mac_table_entry_access.sv
/*
 Entry data registers for indirect address-table access, the
 static table control sequence, lookup resolution and aging.
 Assumes a host on the register port and an external hash
 engine that supplies lookup-table entries; all inputs are
 synchronous to CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Flags bit 31 set means static, never aged
// - Source-drop bit discards matching source packets
// - Destination-drop bit discards matching destination packets
// - Aging_counter reloads on access, decrements per pass
// - Dynamic entry with zero age is invalid
// - Span-tree group compared during destination lookups
// - Bypass bit overrides port state when set
// - Forward mask, bit 0 is port 1
// - Word three filter id, MAC high; four MAC low
// - Sixteen static entries, host only, never aged
// - Search all tables; static beats dynamic
// - Start bit self-clears when access finishes
// - Static entry bit 31 valid, 28:26 priority
// - Table select zero targets static table
// - Empty lookup read returns all-zero words
module mac_table_entry_access
   import mac_entry_pkg::*;
#(
   parameter int ENTRIES = STATIC_ENTRIES
)
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [31:0] REG_WDATA_I,
   output logic [31:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   input wire logic LU_LOAD_I,
   input wire logic LU_FOUND_I,
   input wire logic [127:0] LU_ENTRY_I,
   input wire logic LK_REQ_I,
   input wire logic [47:0] LK_DA_I,
   input wire logic [47:0] LK_SA_I,
   input wire logic [FGID_W-1:0] LK_FGID_I,
   input wire logic [GROUP_W-1:0] LK_GROUP_I,
   input wire logic LK_DYN_HIT_I,
   input wire logic [127:0] LK_DYN_ENTRY_I,
   input wire logic LK_SA_HIT_I,
   input wire logic [31:0] LK_SA_FLAGS_I,
   output logic LK_DONE_O,
   output logic LK_HIT_O,
   output logic LK_STATIC_O,
   output logic LK_DROP_O,
   output logic [FWD_W-1:0] LK_FWD_O,
   output logic LK_BYPASS_O,
   output logic [PRIO_W-1:0] LK_PRIO_O,
   input wire logic AGE_REQ_I,
   input wire logic AGE_LEARN_I,
   input wire logic [31:0] AGE_FLAGS_I,
   output logic [31:0] AGE_FLAGS_O,
   output logic AGE_VALID_O,
   output logic AGE_DONE_O
);
   // ==========================================
   // Static table and carrier
   table_if tbl();

   static_table #(
      .ENTRIES(ENTRIES)
   ) u_table (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .port(tbl)
   );

   // ==========================================
   // Control register and access sequence
   op_state_type state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [IDX_W-1:0] idx_q;
   logic sel_q;
   logic act_q;
   logic busy;
   logic launch;
   logic finish;
   logic rd_done;

   assign busy = (state_q == ST_RUN);
   assign launch = REG_WR_I && (REG_ADDR_I == CTRL_OFF) && !busy
      && REG_WDATA_I[GO_BIT];
   assign finish = busy && (cnt_q == '0);

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (launch)
               begin
                  state_q <= ST_RUN;
                  cnt_q <= OP_LAST;
               end
            end
            ST_RUN:
            begin
               if (cnt_q == '0)
                  state_q <= ST_IDLE;
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Fields are frozen for the whole access
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         idx_q <= '0;
         sel_q <= 1'b0;
         act_q <= 1'b0;
      end
      else if (launch)
      begin
         idx_q <= REG_WDATA_I[IDX_LSB +: IDX_W];
         sel_q <= REG_WDATA_I[SEL_BIT];
         act_q <= REG_WDATA_I[ACT_BIT];
      end
   end

   // Select one is the multicast table, not held here: the
   // access just completes with no data effect.
   assign tbl.idx = idx_q[STATIC_IDX_W-1:0];
   assign tbl.wr_en = finish && !sel_q && !act_q;
   assign rd_done = finish && !sel_q && act_q;

   // ==========================================
   // Entry data words
   logic [31:0] words_q [WORDS];
   logic [31:0] lu_words [WORDS];
   logic [31:0] st_words [WORDS];

   for (genvar w = 0; w < WORDS; w++)
   begin : g_word
      assign lu_words[w] = LU_ENTRY_I[127 - 32 * w -: 32];
      assign st_words[w] = tbl.rdata[127 - 32 * w -: 32];

      // Host writes during an access are dropped so the
      // table never sees a half-updated entry.
      always_ff @(posedge CLK_I)
      begin
         if (RST_I)
            words_q[w] <= WORD_RESET;
         else if (LU_LOAD_I)
            words_q[w] <= LU_FOUND_I ?
               (lu_words[w] & WORD_MASK[w]) : WORD_RESET;
         else if (rd_done)
            words_q[w] <= st_words[w] & WORD_MASK[w];
         else if (REG_WR_I && !busy && REG_ADDR_I == WORD_OFF[w])
            words_q[w] <= REG_WDATA_I & WORD_MASK[w];
      end
   end

   assign tbl.wdata = {words_q[0], words_q[1], words_q[2],
      words_q[3]};

   // ==========================================
   // Register read port
   logic [31:0] rd_mux;
   logic [31:0] rdata_q;
   logic rvalid_q;

   always_comb
   begin
      rd_mux = '0;
      if (REG_ADDR_I == CTRL_OFF)
      begin
         rd_mux[IDX_LSB +: IDX_W] = idx_q;
         rd_mux[SEL_BIT] = sel_q;
         rd_mux[ACT_BIT] = act_q;
         rd_mux[GO_BIT] = busy;
      end
      for (int w = 0; w < WORDS; w++)
         if (REG_ADDR_I == WORD_OFF[w])
            rd_mux = words_q[w];
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= REG_RD_I;
         if (REG_RD_I)
            rdata_q <= rd_mux;
      end
   end

   assign REG_RDATA_O = rdata_q;
   assign REG_RVALID_O = rvalid_q;

   // ==========================================
   // Destination and source lookup
   logic [31:0] dyn_flags;
   logic [31:0] dyn_fwd;
   logic [47:0] dyn_mac;
   logic dyn_ok;
   logic use_st;
   logic use_dyn;
   logic hit;
   logic is_static;
   logic sa_src;
   logic [31:0] ch_flags;
   logic [31:0] ch_fwd;

   assign tbl.da = LK_DA_I;
   assign tbl.sa = LK_SA_I;
   assign tbl.fgid = LK_FGID_I;
   assign tbl.group = LK_GROUP_I;

   assign dyn_flags = LK_DYN_ENTRY_I[127:96];
   assign dyn_fwd = LK_DYN_ENTRY_I[95:64];
   assign dyn_mac = {LK_DYN_ENTRY_I[MACHI_W+31:32],
      LK_DYN_ENTRY_I[31:0]};
   assign dyn_ok = LK_DYN_HIT_I && entry_live(dyn_flags)
      && dyn_mac == LK_DA_I
      && dyn_flags[GROUP_LSB +: GROUP_W] == LK_GROUP_I;

   // Static table first, then the lookup-table result
   assign use_st = tbl.da_hit;
   assign use_dyn = !tbl.da_hit && dyn_ok;
   assign hit = use_st || use_dyn;
   assign is_static = use_st
      || (use_dyn && dyn_flags[STATIC_BIT]);
   assign ch_flags = use_st ? tbl.da_entry.flags : dyn_flags;
   assign ch_fwd = use_st ? tbl.da_entry.fwd : dyn_fwd;
   assign sa_src = LK_SA_HIT_I && entry_live(LK_SA_FLAGS_I)
      && LK_SA_FLAGS_I[SRC_DROP_BIT];

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         LK_DONE_O <= 1'b0;
         LK_HIT_O <= 1'b0;
         LK_STATIC_O <= 1'b0;
         LK_DROP_O <= 1'b0;
         LK_FWD_O <= '0;
         LK_BYPASS_O <= 1'b0;
         LK_PRIO_O <= '0;
      end
      else
      begin
         LK_DONE_O <= LK_REQ_I;
         if (LK_REQ_I)
         begin
            LK_HIT_O <= hit;
            LK_STATIC_O <= is_static;
            LK_DROP_O <= (hit && ch_flags[DST_DROP_BIT])
               || tbl.sa_drop || sa_src;
            LK_FWD_O <= hit ? ch_fwd[FWD_W-1:0] : '0;
            LK_BYPASS_O <= hit && ch_fwd[BYPASS_BIT];
            LK_PRIO_O <= is_static ?
               ch_flags[PRIO_LSB +: PRIO_W] : '0;
         end
      end
   end

   // ==========================================
   // Aging pass
   logic [31:0] age_flags_d;
   logic age_valid_d;

   entry_ager u_ager (
      .flags_i(AGE_FLAGS_I),
      .learn_i(AGE_LEARN_I),
      .flags_o(age_flags_d),
      .valid_o(age_valid_d)
   );

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         AGE_FLAGS_O <= '0;
         AGE_VALID_O <= 1'b0;
         AGE_DONE_O <= 1'b0;
      end
      else
      begin
         AGE_DONE_O <= AGE_REQ_I;
         if (AGE_REQ_I)
         begin
            AGE_FLAGS_O <= age_flags_d;
            AGE_VALID_O <= age_valid_d;
         end
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   sequence s_launch;
      launch;
   endsequence

   sequence s_run;
      busy [*2] ##1 !busy;
   endsequence

   chk_go_clears:
      assert property (s_launch |=> s_run)
      else $error("Start bit did not clear on time");

   chk_static_write:
      assert property (tbl.wr_en |=> tbl.rdata == $past(tbl.wdata))
      else $error("Static entry not stored");

   chk_read_load:
      assert property (rd_done && !LU_LOAD_I |=>
         words_q[0] == ($past(st_words[0]) & WORD_MASK[0]))
      else $error("Static read not loaded");

   chk_empty_zero:
      assert property (LU_LOAD_I && !LU_FOUND_I |=>
         words_q[0] == '0 && words_q[1] == '0
         && words_q[2] == '0 && words_q[3] == '0)
      else $error("Empty lookup read not zero");

   chk_reserved_zero:
      assert property ((words_q[1] & ~WORD_MASK[1]) == '0
         && (words_q[2] & ~WORD_MASK[2]) == '0)
      else $error("Reserved bits not zero");

   chk_static_wins:
      assert property (LK_REQ_I && tbl.da_hit |=>
         LK_HIT_O && LK_STATIC_O && LK_DONE_O)
      else $error("Static result lost");

   chk_dst_drop:
      assert property (LK_REQ_I && tbl.da_hit
         && tbl.da_entry.flags[DST_DROP_BIT] |=> LK_DROP_O)
      else $error("Destination drop missed");

   chk_src_drop:
      assert property (LK_REQ_I && tbl.sa_drop |=> LK_DROP_O)
      else $error("Source drop missed");

   chk_aged_invalid:
      assert property (LK_REQ_I && !tbl.da_hit && !dyn_flags[STATIC_BIT]
         && dyn_flags[PRIO_LSB +: PRIO_W] == '0 |=> !LK_HIT_O)
      else $error("Expired entry used");

   chk_fwd_mask:
      assert property (LK_REQ_I && tbl.da_hit |=>
         LK_FWD_O == $past(tbl.da_entry.fwd[FWD_W-1:0]))
      else $error("Forward mask wrong");

   chk_age_reload:
      assert property (AGE_REQ_I && AGE_LEARN_I
         && !AGE_FLAGS_I[STATIC_BIT] |=>
         AGE_FLAGS_O[PRIO_LSB +: PRIO_W] == AGE_DEFAULT && AGE_VALID_O)
      else $error("Aging_counter not reloaded");

endmodule
`default_nettype wire

// ### tb/engine_model.sv
/*
 Behavioural model of the hash engine beside the entry register bank.
 Assumes one shared clock; the bench drives it through its two tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module engine_model
(
   input wire logic clk_i,
   input wire logic [47:0] da_i,
   input wire logic [47:0] sa_i,
   output logic lu_load_o,
   output logic lu_found_o,
   output logic [127:0] lu_entry_o,
   output logic dyn_hit_o,
   output logic [127:0] dyn_entry_o,
   output logic sa_hit_o,
   output logic [31:0] sa_flags_o
);
   // ==========================================
   // One held candidate, searched by address
   logic [127:0] held;

   initial
   begin
      held = '0;
      lu_load_o = 1'b0;
      lu_found_o = 1'b0;
      lu_entry_o = '0;
   end

   assign dyn_hit_o = (held[47:0] == da_i);
   // On a miss the buses carry garbage, never a stale copy
   assign dyn_entry_o = dyn_hit_o ? held : ~held;
   assign sa_hit_o = (held[47:0] == sa_i);
   assign sa_flags_o = sa_hit_o ? held[127:96] : ~held[127:96];

   task automatic learn(input logic [127:0] e);
      @(posedge clk_i);
      held <= e;
   endtask

   // Table read result after a chosen number of idle cycles
   task automatic answer(input int dly, input logic found,
      input logic [127:0] e);
      repeat (dly) @(posedge clk_i);
      @(posedge clk_i);
      lu_load_o <= 1'b1;
      lu_found_o <= found;
      lu_entry_o <= e;
      @(posedge clk_i);
      lu_load_o <= 1'b0;
      lu_entry_o <= ~e;
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 Self-checking bench for the entry register bank and static table.
 Assumes the engine model answers lookup-table reads and candidates.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import mac_entry_pkg::*;
;
   localparam logic [127:0] ST_E = {32'h9400_0005, 32'h8000_0055,
      32'h002A_1234, 32'h5678_9ABC};
   localparam logic [127:0] DROP_E = {32'hE000_0005, 32'h0000_0001,
      32'h002A_0000, 32'h0000_0077};
   localparam logic [127:0] DYN_E = {32'h0C00_0005, 32'h0000_0002,
      32'h002A_1234, 32'h5678_9ABC};
   localparam logic [95:0] DYN_T = {32'h8000_0012, 32'h002A_AAAA,
      32'h0000_0001};
   localparam logic [47:0] DYN_MAC = 48'hAAAA_0000_0001;
   logic clk, rst, wr, rd, rvalid, lk_req, age_req, age_learn;
   logic lu_load, lu_found, dyn_hit, sa_hit, lk_done, lk_hit;
   logic lk_static, lk_drop, lk_bypass, age_valid, age_done;
   logic [15:0] addr;
   logic [31:0] wdata, rdata, sa_flags, age_flags, age_flags_o;
   logic [127:0] lu_entry, dyn_entry;
   logic [47:0] da, sa;
   logic [FGID_W-1:0] fgid;
   logic [GROUP_W-1:0] grp;
   logic [FWD_W-1:0] lk_fwd;
   logic [PRIO_W-1:0] lk_prio;
   int failures;
   int check_count;

   mac_table_entry_access mac_table_entry_access_i (.CLK_I(clk),
      .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .LU_LOAD_I(lu_load), .LU_FOUND_I(lu_found), .LU_ENTRY_I(lu_entry),
      .LK_REQ_I(lk_req), .LK_DA_I(da), .LK_SA_I(sa), .LK_FGID_I(fgid),
      .LK_GROUP_I(grp), .LK_DYN_HIT_I(dyn_hit),
      .LK_DYN_ENTRY_I(dyn_entry), .LK_SA_HIT_I(sa_hit),
      .LK_SA_FLAGS_I(sa_flags), .LK_DONE_O(lk_done), .LK_HIT_O(lk_hit),
      .LK_STATIC_O(lk_static), .LK_DROP_O(lk_drop), .LK_FWD_O(lk_fwd),
      .LK_BYPASS_O(lk_bypass), .LK_PRIO_O(lk_prio),
      .AGE_REQ_I(age_req), .AGE_LEARN_I(age_learn),
      .AGE_FLAGS_I(age_flags), .AGE_FLAGS_O(age_flags_o),
      .AGE_VALID_O(age_valid), .AGE_DONE_O(age_done));

   engine_model engine_model_i (.clk_i(clk), .da_i(da), .sa_i(sa),
      .lu_load_o(lu_load), .lu_found_o(lu_found), .lu_entry_o(lu_entry),
      .dyn_hit_o(dyn_hit), .dyn_entry_o(dyn_entry), .sa_hit_o(sa_hit),
      .sa_flags_o(sa_flags));

   // ==========================================
   // Reporting
   task automatic chk(input string what, input logic [127:0] seen,
      input logic [127:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic give_up;
      failures++;
      wrap_up();
   endtask

   // ==========================================
   // Register port
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      int n;
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      n = 0;
      while (rvalid !== 1'b1 && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4)
         give_up();
      d = rdata;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk("register read", 128'(d), 128'(e));
   endtask

   task automatic load(input logic [127:0] e);
      for (int i = 0; i < WORDS; i++)
         wr_reg(WORD_OFF[i], e[127-32*i -: 32]);
   endtask

   task automatic words(input logic [127:0] e);
      for (int i = 0; i < WORDS; i++)
         rd_chk(WORD_OFF[i], e[127-32*i -: 32]);
   endtask

   // Start, then poll the go bit under a bound
   task automatic table_op(input logic [5:0] idx, input logic sel, act);
      logic [31:0] c;
      int n;
      wr_reg(CTRL_OFF, {19'h0, 1'b1, 2'h0, act, sel, 2'h0, idx});
      c = 32'h0000_1000;
      n = 0;
      while (c[GO_BIT] !== 1'b0 && n < 8)
      begin
         rd_reg(CTRL_OFF, c);
         n++;
      end
      if (n == 8)
         give_up();
      chk("go bit", 128'(c[GO_BIT]), 128'h0);
   endtask

   // ==========================================
   // Lookup and aging ports
   task automatic lk(input logic [47:0] d, s, input logic [2:0] g,
      input logic [13:0] e, m);
      @(posedge clk);
      da <= d;
      sa <= s;
      grp <= g;
      lk_req <= 1'b1;
      @(posedge clk);
      lk_req <= 1'b0;
      #1;
      chk("lookup done", 128'(lk_done), 128'h1);
      chk("lookup result", 128'({lk_hit, lk_static, lk_drop, lk_bypass,
         lk_fwd, lk_prio} & m), 128'(e));
   endtask

   task automatic age(input logic l, input logic [31:0] f, e,
      input logic v);
      @(posedge clk);
      age_req <= 1'b1;
      age_learn <= l;
      age_flags <= f;
      @(posedge clk);
      age_req <= 1'b0;
      #1;
      chk("aging", 128'({age_done, age_valid, age_flags_o}),
         128'({1'b1, v, e}));
   endtask

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial
   begin
      rst = 1'b1;
      {wr, rd, lk_req, age_req, age_learn} = '0;
      addr = '0;
      wdata = '0;
      da = '1;
      sa = '0;
      fgid = 7'h2A;
      grp = '0;
      age_flags = '0;
      failures = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      words('0);
      for (int i = 0; i < WORDS; i++)
      begin
         wr_reg(WORD_OFF[i], 32'hFFFF_FFFF);
         rd_chk(WORD_OFF[i], WORD_MASK[i]);
      end
      load(ST_E);
      table_op(6'd15, 1'b0, 1'b0);
      load(DROP_E);
      table_op(6'd0, 1'b0, 1'b0);
      load('0);
      table_op(6'd15, 1'b0, 1'b1);
      words(ST_E);
      load(DYN_E);
      table_op(6'd15, 1'b1, 1'b1);
      words(DYN_E);
      engine_model_i.learn(DYN_E);
      lk(48'h1234_5678_9ABC, '0, 3'h5, 14'h36AD, '1);
      lk(48'h77, '0, 3'h5, 14'h3808, '1);
      fgid <= 7'h2B;
      lk(48'h77, '0, 3'h5, 14'h0, 14'h2000);
      fgid <= 7'h2A;
      engine_model_i.learn({32'h0000_0003, DYN_T});
      lk(DYN_MAC, '0, 3'h3, 14'h0, 14'h2000);
      engine_model_i.learn({32'h0C00_0003, DYN_T});
      lk(DYN_MAC, '0, 3'h3, 14'h2490, 14'h3FF8);
      lk(DYN_MAC, '0, 3'h4, 14'h0, 14'h2000);
      engine_model_i.learn({32'h4C00_0003, DYN_T});
      lk(48'h1, DYN_MAC, 3'h3, 14'h0800, 14'h0800);
      lk(48'h1, 48'h77, 3'h5, 14'h0800, 14'h0800);
      engine_model_i.answer(2, 1'b1, {32'h0C00_0003, DYN_T});
      words({32'h0C00_0003, DYN_T});
      engine_model_i.answer(0, 1'b0, {32'h0C00_0003, DYN_T});
      words('0);
      age(1'b1, 32'h0000_0003, 32'h1C00_0003, 1'b1);
      age(1'b0, 32'h0C00_0003, 32'h0800_0003, 1'b1);
      age(1'b0, 32'h0400_0003, 32'h0000_0003, 1'b0);
      age(1'b0, 32'h8400_0003, 32'h8400_0003, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
